// ---- rtl/oax_pkg.sv ----
// Package with constants and types for the operand address extraction block.
package oax_pkg;

  // ----------------------------------------------------------------
  // Address widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned VAR_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [VAR_W-1:0] VAR_RST = 6'h00;
  localparam logic [ADDR_W-1:0] ACTIVE16_MASK = 17'h0ffff;
  localparam logic [ADDR_W-1:0] ACTIVE17_MASK = 17'h1ffff;
  // Largest memory (in characters, minus one) still served by 16 active bits.
  localparam logic [ADDR_W:0] MEM16_LIMIT = 18'h0ffff;

  // ----------------------------------------------------------------
  // Instruction address formats
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    OAX_FMT_BOTH = 2'h0,
    OAX_FMT_DUP_A = 2'h1,
    OAX_FMT_KEEP_B = 2'h2,
    OAX_FMT_NONE = 2'h3
  } oax_fmt_t;

  // Variant handling for an instruction that carries no variant character.
  typedef enum logic [1:0]
  {
    OAX_VAR_KEEP = 2'h0,
    OAX_VAR_LOAD = 2'h1,
    OAX_VAR_SPECIAL = 2'h2
  } oax_var_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    OAX_IDLE,
    OAX_CHECK,
    OAX_RUN
  } oax_state_t;

endpackage

// ---- rtl/oax_operand_address.sv ----
// Operand address extraction, range check and chaining registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Out-of-memory address halts when protection off and multichar_i set.
// - Protected out-of-memory: flag, terminate, interrupt.
// - Oversized address wraps modulo active range.
// - Explicit format takes both fields from instruction.
// - Duplicate-A format loads A into both.
// - Duplicate copy moves every bit, bank included.
// - Preserve-B format loads A, keeps B.
// - No-address format reuses previous A and B.
// - Completion leaves registers at adjacent fields.
// - Variant character loads into variant register.
// - No-variant instruction keeps variant, with exceptions.
// - Variant reuse allowed in all four formats.
// - Active bits: 16 to 64K, 17 beyond.
// - Indexing adds index binary inside address register.
module oax_operand_address
  import oax_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W:0] mem_top_i,
  input wire logic multichar_i,
  input wire logic protect_i,
  input wire logic start_i,
  input wire logic [1:0] fmt_i,
  input wire logic [ADDR_W-1:0] a_field_i,
  input wire logic [ADDR_W-1:0] a_index_i,
  input wire logic a_indexed_i,
  input wire logic [ADDR_W-1:0] b_field_i,
  input wire logic [ADDR_W-1:0] b_index_i,
  input wire logic b_indexed_i,
  input wire logic has_variant_i,
  input wire logic [VAR_W-1:0] variant_i,
  input wire logic [1:0] var_mode_i,
  input wire logic [VAR_W-1:0] special_variant_i,
  input wire logic done_i,
  input wire logic [ADDR_W-1:0] a_next_i,
  input wire logic [ADDR_W-1:0] b_next_i,
  input wire logic viol_clear_i,
  output logic [ADDR_W-1:0] a_operand_address_register_o,
  output logic [ADDR_W-1:0] b_operand_address_register_o,
  output logic [VAR_W-1:0] variant_o,
  output logic addr_ready_o,
  output logic halt_o,
  output logic terminate_o,
  output logic internal_interrupt_o,
  output logic addr_violation_o,
  output logic busy_o
);

  // ----------------------------------------------------------------
  // Active address range
  // ----------------------------------------------------------------
  // The memory size is treated as a static strap; sampling it each cycle
  // costs nothing and keeps reset free of port values.
  logic [ADDR_W-1:0] active_mask;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      active_mask <= ACTIVE16_MASK;
    end
    else if (mem_top_i > MEM16_LIMIT)
    begin
      active_mask <= ACTIVE17_MASK;
    end
    else
    begin
      active_mask <= ACTIVE16_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Effective address forming
  // ----------------------------------------------------------------
  logic [ADDR_W:0] a_sum;
  logic [ADDR_W:0] b_sum;
  logic [ADDR_W-1:0] a_eff;
  logic [ADDR_W-1:0] b_eff;
  oax_fmt_t fmt;

  assign fmt = oax_fmt_t'(fmt_i);
  assign a_sum = {1'b0, a_field_i} + (a_indexed_i ? {1'b0, a_index_i} : 18'h00000);
  assign b_sum = {1'b0, b_field_i} + (b_indexed_i ? {1'b0, b_index_i} : 18'h00000);
  // Dropping the carry and masking gives the modulo wrap in one step.
  assign a_eff = a_sum[ADDR_W-1:0] & active_mask;
  assign b_eff = b_sum[ADDR_W-1:0] & active_mask;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  oax_state_t state;
  logic bad_addr;
  oax_fmt_t held_fmt;

  // The format is captured with the start strobe, so a format input that
  // moves on during the check cannot change which operands are checked.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      held_fmt <= OAX_FMT_BOTH;
    end
    else if (state == OAX_IDLE && start_i)
    begin
      held_fmt <= fmt;
    end
  end

  // Only freshly extracted operands are checked; reused values are not,
  // and those loaded at completion are never checked.
  always_comb
  begin
    bad_addr = 1'b0;
    if (held_fmt != OAX_FMT_NONE && {1'b0, a_operand_address_register_o} > mem_top_i)
      bad_addr = 1'b1;
    if (held_fmt == OAX_FMT_BOTH && {1'b0, b_operand_address_register_o} > mem_top_i)
      bad_addr = 1'b1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      state <= OAX_IDLE;
    else
    begin
      unique case (state)
        OAX_IDLE:
          if (start_i)
          begin
            state <= OAX_CHECK;
          end
        OAX_CHECK:
          if (bad_addr && !protect_i && multichar_i)
          begin
            state <= OAX_IDLE;
          end
          else if (bad_addr && protect_i)
          begin
            state <= OAX_IDLE;
          end
          else
          begin
            state <= OAX_RUN;
          end
        OAX_RUN:
          if (done_i)
          begin
            state <= OAX_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      busy_o <= 1'b0;
    end
    else if (state == OAX_IDLE && start_i)
    begin
      busy_o <= 1'b1;
    end
    else if (state == OAX_CHECK && bad_addr && (protect_i || multichar_i))
    begin
      busy_o <= 1'b0;
    end
    else if (state == OAX_RUN && done_i)
    begin
      busy_o <= 1'b0;
    end
  end

  // Memory access is allowed once the check has passed, or after a failed check with neither protect_i nor multichar_i set.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      addr_ready_o <= 1'b0;
    else
      addr_ready_o <= state == OAX_CHECK && !(bad_addr && (protect_i || multichar_i));
  end

  // ----------------------------------------------------------------
  // Violation handling
  // ----------------------------------------------------------------
  logic viol_event;
  assign viol_event = state == OAX_CHECK && bad_addr;

  // Halt is held until reset; the stopped processor needs an operator.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      halt_o <= 1'b0;
    end
    else if (viol_event && !protect_i && multichar_i)
    begin
      halt_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      terminate_o <= 1'b0;
      internal_interrupt_o <= 1'b0;
    end
    else
    begin
      terminate_o <= viol_event && protect_i;
      internal_interrupt_o <= viol_event && protect_i;
    end
  end

  // The set wins over a clear arriving in the same cycle.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      addr_violation_o <= 1'b0;
    end
    else if (viol_event && protect_i)
    begin
      addr_violation_o <= 1'b1;
    end
    else if (viol_clear_i)
    begin
      addr_violation_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Operand address registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      a_operand_address_register_o <= ADDR_RST;
    end
    else if (state == OAX_IDLE && start_i && fmt != OAX_FMT_NONE)
    begin
      a_operand_address_register_o <= a_eff;
    end
    else if (state == OAX_RUN && done_i)
    begin
      a_operand_address_register_o <= a_next_i & active_mask;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      b_operand_address_register_o <= ADDR_RST;
    end
    else if (state == OAX_IDLE && start_i)
    begin
      unique case (fmt)
        OAX_FMT_BOTH:
        begin
          b_operand_address_register_o <= b_eff;
        end
        OAX_FMT_DUP_A:
        begin
          b_operand_address_register_o <= a_eff;
        end
        OAX_FMT_KEEP_B:
        begin
          b_operand_address_register_o <= b_operand_address_register_o;
        end
        OAX_FMT_NONE:
        begin
          b_operand_address_register_o <= b_operand_address_register_o;
        end
      endcase
    end
    else if (state == OAX_RUN && done_i)
    begin
      b_operand_address_register_o <= b_next_i & active_mask;
    end
  end

  // ----------------------------------------------------------------
  // Variant register
  // ----------------------------------------------------------------
  // The variant path ignores the format, so chaining works in all of them.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      variant_o <= VAR_RST;
    end
    else if (state == OAX_IDLE && start_i)
    begin
      if (has_variant_i)
      begin
        variant_o <= variant_i;
      end
      else if (oax_var_t'(var_mode_i) == OAX_VAR_SPECIAL)
      begin
        variant_o <= special_variant_i;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/oax_seq_model.sv ----
// Model of instruction sequencing that ends each instruction after a delay.
`timescale 1ns/1ps
`default_nettype none
module oax_seq_model
  import oax_pkg::*;
#(
  parameter int DLY = 3
)
(
  input wire logic ref_clk_i,
  input wire logic ready_i,
  input wire logic [ADDR_W-1:0] a_i,
  input wire logic [ADDR_W-1:0] b_i,
  output logic done_o,
  output logic [ADDR_W-1:0] a_next_o,
  output logic [ADDR_W-1:0] b_next_o
);
  // Next addresses are inverted while not valid, so a stale value never passes.
  initial
  begin
    done_o = 1'b0;
    a_next_o = '1;
    b_next_o = '1;
    forever
    begin
      @(negedge ref_clk_i);
      if (ready_i === 1'b1)
      begin
        repeat (DLY) @(negedge ref_clk_i);
        done_o = 1'b1;
        a_next_o = a_i - 17'h0000a;
        b_next_o = b_i - 17'h0000a;
        @(negedge ref_clk_i);
        done_o = 1'b0;
        a_next_o = ~a_next_o;
        b_next_o = ~b_next_o;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/oax_chk.sv ----
// Concurrent checks on the operand address block ports.
`timescale 1ns/1ps
`default_nettype none
module oax_chk
  import oax_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W:0] mem_top_i,
  input wire logic start_i,
  input wire logic [1:0] fmt_i,
  input wire logic [ADDR_W-1:0] a_field_i,
  input wire logic [ADDR_W-1:0] a_index_i,
  input wire logic a_indexed_i,
  input wire logic has_variant_i,
  input wire logic [VAR_W-1:0] variant_i,
  input wire logic [1:0] var_mode_i,
  input wire logic done_i,
  input wire logic [ADDR_W-1:0] a_next_i,
  input wire logic viol_clear_i,
  input wire logic [ADDR_W-1:0] a_operand_address_register_o,
  input wire logic [ADDR_W-1:0] b_operand_address_register_o,
  input wire logic [VAR_W-1:0] variant_o,
  input wire logic addr_ready_o,
  input wire logic halt_o,
  input wire logic terminate_o,
  input wire logic internal_interrupt_o,
  input wire logic addr_violation_o,
  input wire logic busy_o
);
  logic [ADDR_W-1:0] a, b, m, ea;
  logic tk;
  assign a = a_operand_address_register_o;
  assign b = b_operand_address_register_o;
  assign m = (mem_top_i > MEM16_LIMIT) ? ACTIVE17_MASK : ACTIVE16_MASK;
  assign ea = (a_field_i + (a_indexed_i ? a_index_i : '0)) & m;
  assign tk = start_i && !busy_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_ANSWER: assert property (tk |-> ##2 (addr_ready_o || terminate_o || halt_o))
    else $error("no answer two cycles after start");
  AST_A_LOAD: assert property ($past(rst_b_i) && tk && fmt_i != 2'h3 |=> a == $past(ea))
    else $error("A address not the wrapped effective address");
  AST_DUP: assert property (tk && fmt_i == 2'h1 |=> b == a)
    else $error("B differs from A after duplicate load");
  AST_KEEP: assert property (tk && fmt_i == 2'h2 |=> $stable(b))
    else $error("B changed on preserve load");
  AST_NONE: assert property (tk && fmt_i == 2'h3 |=> $stable(a) && $stable(b))
    else $error("registers changed on implicit load");
  AST_DONE: assert property (done_i && busy_o |=> a == ($past(a_next_i) & m))
    else $error("A not left at next field");
  AST_VLOAD: assert property (tk && has_variant_i |=> variant_o == $past(variant_i))
    else $error("variant not loaded");
  AST_VKEEP: assert property (tk && !has_variant_i && var_mode_i == 2'h0 |=> $stable(variant_o))
    else $error("variant changed without a variant character");
  AST_TERM: assert property (terminate_o |-> internal_interrupt_o && addr_violation_o && !addr_ready_o)
    else $error("termination without interrupt and flag");
  AST_STICKY: assert property (addr_violation_o && !viol_clear_i |=> addr_violation_o)
    else $error("violation flag dropped");
  AST_HALT: assert property (halt_o |=> halt_o && !addr_ready_o)
    else $error("halt released or access granted");
endmodule
bind oax_operand_address oax_chk u_oax_chk (.*);
`default_nettype wire

// ---- tb/oax_operand_address_tb.sv ----
// Self-checking bench for the operand address block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module oax_operand_address_tb
  import oax_pkg::*;
;
  logic ref_clk_i = 0, rst_b_i = 0, multichar_i = 0, protect_i = 0, start_i = 0;
  logic [ADDR_W:0] mem_top_i = 18'h0bfff;
  logic [1:0] fmt_i = 0, var_mode_i = 0;
  logic [ADDR_W-1:0] a_field_i = 0, a_index_i = 0, b_field_i = 0, b_index_i = 0;
  logic a_indexed_i = 0, b_indexed_i = 0, has_variant_i = 0, viol_clear_i = 0;
  logic [VAR_W-1:0] variant_i = 0, special_variant_i = 6'h2a, variant_o;
  logic done_i;
  logic [ADDR_W-1:0] a_next_i, b_next_i, a_operand_address_register_o, b_operand_address_register_o;
  logic addr_ready_o, halt_o, terminate_o, internal_interrupt_o, addr_violation_o, busy_o;
  int err_total = 0, tests_run = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  oax_operand_address u_oax_operand_address (.*);
  oax_seq_model u_oax_seq_model (.ref_clk_i(ref_clk_i), .ready_i(addr_ready_o),
    .a_i(a_operand_address_register_o), .b_i(b_operand_address_register_o),
    .done_o(done_i), .a_next_o(a_next_i), .b_next_o(b_next_i));
  task automatic complete_run();
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reset_dut();
    @(negedge ref_clk_i);
    rst_b_i = 0;
    repeat (16) @(negedge ref_clk_i);
    rst_b_i = 1;
    repeat (2) @(negedge ref_clk_i);
  endtask
  // Leaves the bench at the falling edge where the answer stands.
  task automatic issue(input logic [1:0] f, input logic [ADDR_W-1:0] a, ai, b);
    @(negedge ref_clk_i);
    fmt_i = f;
    a_field_i = a;
    a_index_i = ai;
    a_indexed_i = (ai != 0);
    b_field_i = b;
    start_i = 1;
    @(negedge ref_clk_i);
    start_i = 0;
    @(negedge ref_clk_i);
  endtask
  task automatic finish_op();
    int n = 0;
    while (busy_o !== 1'b0 && n < 200)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 200)
    begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic t_chain();
    has_variant_i = 1;
    variant_i = 6'h15;
    b_index_i = 17'h000b2;
    b_indexed_i = 1;
    issue(2'h0, 17'h00384, 0, 17'h00200);
    `CHK("rdy", 1'b1, addr_ready_o)
    `CHK("a", 17'h00384, a_operand_address_register_o)
    `CHK("b", 17'h002b2, b_operand_address_register_o)
    `CHK("var", 6'h15, variant_o)
    finish_op();
    `CHK("a", 17'h0037a, a_operand_address_register_o)
    has_variant_i = 0;
    b_indexed_i = 0;
    issue(2'h3, 17'h1ffff, 0, 17'h1ffff);
    `CHK("b", 17'h002a8, b_operand_address_register_o)
    `CHK("var", 6'h15, variant_o)
    finish_op();
    `CHK("b", 17'h0029e, b_operand_address_register_o)
  endtask
  task automatic t_dup_keep();
    issue(2'h1, 17'h01230, 17'h00004, 17'h1ffff);
    `CHK("b", 17'h01234, b_operand_address_register_o)
    finish_op();
    var_mode_i = 2;
    issue(2'h2, 17'h00100, 0, 17'h1ffff);
    `CHK("a", 17'h00100, a_operand_address_register_o)
    `CHK("b", 17'h0122a, b_operand_address_register_o)
    `CHK("var", 6'h2a, variant_o)
    finish_op();
    var_mode_i = 0;
    issue(2'h1, 17'h0bb80, 17'h06978, 0);
    `CHK("wrap", 17'h024f8, a_operand_address_register_o)
    finish_op();
  endtask
  task automatic t_fault();
    protect_i = 1;
    issue(2'h1, 17'h0c000, 0, 0);
    `CHK("term", 2'b11, {terminate_o, internal_interrupt_o})
    `CHK("rdy", 1'b0, addr_ready_o)
    repeat (3) @(negedge ref_clk_i);
    `CHK("viol", 1'b1, addr_violation_o)
    viol_clear_i = 1;
    @(negedge ref_clk_i);
    viol_clear_i = 0;
    `CHK("viol", 1'b0, addr_violation_o)
    finish_op();
    protect_i = 0;
    multichar_i = 1;
    issue(2'h1, 17'h0c000, 0, 0);
    `CHK("halt", 1'b1, halt_o)
    // The wider memory takes effect a cycle later; the reset clears the held halt.
    mem_top_i = 18'h1ffff;
    reset_dut();
    multichar_i = 0;
    `CHK("halt", 1'b0, halt_o)
    issue(2'h1, 17'h0ffff, 17'h00002, 0);
    `CHK("a17", 17'h10001, a_operand_address_register_o)
    finish_op();
  endtask
  initial
  begin
    reset_dut();
    t_chain();
    t_dup_keep();
    t_fault();
    complete_run();
  end
endmodule
`default_nettype wire
